// ### include/hbdc_pkg.sv
// Constants shared by the host-bus disk controller interface
//------------------------------------------------------------
// Contract
// - Parallel load buffer when idle and loading
// - Shift buffer first to last while busy
// - Shift serial input in, show eight bits
// - Run with done means command, else data
// - Data buffer access sets run flop
// - Initialize or busy clears run flop
// - Busy when request and done negated
// - Inbound: request then run fetches next
// - Outbound: request then run marks arrival
// - Status read gives done, enable, request
// - Count eight bits then append parity
// - Controller error reads as data bit 15
// - Request bus when done, enabled, not busy; code also needs armed_r, set by a done rise while enabled
// - Plug picks request/grant pair, level 5
// - Grant edge sets acknowledge flop
// - All negated: drop acknowledge, take busy
// - As master assert interrupt and vector
// - Vector drivers on data lines 8..2
// - Address bit 1 selects data or status
// - Status drives lines 4-7 and 15, data 0-7
//------------------------------------------------------------
package hbdc_pkg;
    // Buffer and bus widths
    localparam int BUF_W = 8;
    localparam int DATA_W = 16;
    localparam int LEVELS = 4;
    // Bits per element before parity
    localparam logic [3:0] ELEM_BITS = 4'h8;
    // Status field positions
    localparam int CSR_DONE_BIT = 5;
    localparam int CSR_IEN_BIT = 6;
    localparam int CSR_TR_BIT = 7;
    localparam int CSR_ERR_BIT = 15;
    // Vector field on the data lines
    localparam int VEC_LO = 2;
    localparam int VEC_HI = 8;
    localparam logic [8:0] VECTOR_DEF = 9'h0_0B4;
    // Plug code for the usual level 5
    localparam logic [1:0] PRIO_DEF = 2'h1;
    // Reset values
    localparam logic [BUF_W-1:0] BUF_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [DATA_W-1:0] OE_N_RST = 16'hFFFF;
    // Line enables for reads, active low
    localparam logic [DATA_W-1:0] OE_N_CSR = 16'h7F0F;
    localparam logic [DATA_W-1:0] OE_N_DB = 16'hFF00;
    localparam logic [DATA_W-1:0] OE_N_VEC = 16'hFE03;
    // Parity sense: 1 makes the element odd
    localparam logic PARITY_ODD = 1'b1;

    // Arbitration states
    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_REQ = 2'b01,
        ARB_SACK = 2'b10,
        ARB_MASTER = 2'b11
    } arb_e;
endpackage : hbdc_pkg

// ### src/hbdc_sync.sv
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ps
module hbdc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // First stage: read only by the second
    logic [W-1:0] meta_r;

    //------------------------------------------------------------
    // Two stages
    //------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_r <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : hbdc_sync

// ### src/hbdc_shift_buf.sv
// Eight-bit parallel-load shift register for the data buffer
`timescale 1ns/1ps
module hbdc_shift_buf (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic load_i,
    input wire logic [hbdc_pkg::BUF_W-1:0] load_data_i,
    input wire logic shift_i,
    input wire logic ser_i,
    output logic [hbdc_pkg::BUF_W-1:0] q_o
);
    //------------------------------------------------------------
    // Load has priority; shift moves stage 0 toward stage 7
    //------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q_o <= hbdc_pkg::BUF_RST;
        end
        else if (load_i)
        begin
            q_o <= load_data_i;
        end
        else if (shift_i)
        begin
            q_o <= {q_o[hbdc_pkg::BUF_W-2:0], ser_i};
        end
    end
endmodule : hbdc_shift_buf

// ### src/host_bus_disk_ctrl_interface.sv
// Host bus to disk controller interface: buffer, run, parity, interrupt
`timescale 1ns/1ps
module host_bus_disk_ctrl_interface #(
    // Interrupt vector (bits 8..2 go out on the bus)
    parameter logic [8:0] VECTOR = hbdc_pkg::VECTOR_DEF
) (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    // Host register access pins
    input wire logic HOST_SEL_I,
    input wire logic HOST_A01_I,
    input wire logic HOST_WRITE_I,
    input wire logic [hbdc_pkg::BUF_W-1:0] HOST_DATA_I,
    output logic [hbdc_pkg::DATA_W-1:0] HOST_DATA_O,
    output logic [hbdc_pkg::DATA_W-1:0] HOST_DATA_OE_N_O,
    input wire logic BUS_INIT_I,
    // Arbitration pins
    input wire logic [1:0] PRIO_SEL_I,
    input wire logic [hbdc_pkg::LEVELS-1:0] BUS_BG_I,
    input wire logic BUS_BBSY_I,
    input wire logic BUS_SSYN_I,
    output logic [hbdc_pkg::LEVELS-1:0] BUS_BR_O,
    output logic BUS_SACK_O,
    output logic BUS_BBSY_O,
    output logic BUS_INTR_O,
    // Controller link pins
    input wire logic CTRL_XFER_REQ_I,
    input wire logic CTRL_DONE_I,
    input wire logic CTRL_TO_HOST_DIR_I,
    input wire logic CTRL_SHIFT_I,
    input wire logic CTRL_SERIAL_I,
    input wire logic CTRL_ERROR_I,
    output logic CTRL_RUN_O,
    output logic CTRL_SERIAL_O,
    output logic CTRL_INIT_O
);
    //------------------------------------------------------------
    // Pin synchronisation
    //------------------------------------------------------------
    localparam int SW = 24;

    // Synchronised pin group
    logic [SW-1:0] pins_s;
    // Host side levels after the synchroniser
    logic host_sel, host_a01, host_write, bus_init, bus_bbsy, bus_ssyn;
    logic [hbdc_pkg::BUF_W-1:0] host_data;
    logic [hbdc_pkg::LEVELS-1:0] bg_s;
    // Controller link levels, all through the same two stages
    logic xfer_req, func_done, dir_in, shift_lvl, ser_in, ctrl_err;

    hbdc_sync #(
        .W(SW)
    ) u_sync (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .d_i({BUS_BG_I, HOST_SEL_I, HOST_A01_I, HOST_WRITE_I, HOST_DATA_I,
              BUS_INIT_I, BUS_BBSY_I, BUS_SSYN_I, CTRL_XFER_REQ_I,
              CTRL_DONE_I, CTRL_TO_HOST_DIR_I, CTRL_SHIFT_I,
              CTRL_SERIAL_I, CTRL_ERROR_I}),
        .q_o(pins_s)
    );

    // Unpack the synchronised group, same order as packed
    assign {bg_s, host_sel, host_a01, host_write, host_data} = pins_s[23:9];
    assign {bus_init, bus_bbsy, bus_ssyn, xfer_req, func_done} = pins_s[8:4];
    assign {dir_in, shift_lvl, ser_in, ctrl_err} = pins_s[3:0];

    //------------------------------------------------------------
    // Edge detection on synchronised levels
    //------------------------------------------------------------
    // Last-cycle copies of the levels that need edges
    logic sel_d_r, shift_d_r, done_d_r, grant_d_r;

    // Access strobe: start of a selected host cycle
    logic access_p;
    // Controller shift pulse, rising edge
    logic shift_p;
    // Function done, rising edge
    logic done_rise;
    // Selected grant and its rising edge
    logic grant_in, grant_rise;

    // Grant routed through the priority plug
    function automatic logic pick_level(input logic [hbdc_pkg::LEVELS-1:0] v,
                                        input logic [1:0] sel);
        pick_level = v[sel];
    endfunction : pick_level

    assign grant_in = pick_level(bg_s, PRIO_SEL_I);
    assign access_p = host_sel & ~sel_d_r;
    assign shift_p = shift_lvl & ~shift_d_r;
    assign done_rise = func_done & ~done_d_r;
    assign grant_rise = grant_in & ~grant_d_r;

    // Delayed copies for the edge detectors; initialize relayed alongside
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            sel_d_r <= 1'b0;
            shift_d_r <= 1'b0;
            done_d_r <= 1'b0;
            grant_d_r <= 1'b0;
            CTRL_INIT_O <= 1'b0;
        end
        else
        begin
            sel_d_r <= host_sel;
            shift_d_r <= shift_lvl;
            done_d_r <= func_done;
            grant_d_r <= grant_in;
            CTRL_INIT_O <= bus_init;
        end
    end

    //------------------------------------------------------------
    // Sequencing: busy, direction, load and shift
    //------------------------------------------------------------
    // Controller busy: neither request nor done
    logic ctrl_busy;
    // Host access to the data buffer, read or write
    logic db_access;
    logic parallel_load;
    logic buf_shift;
    logic [hbdc_pkg::BUF_W-1:0] buf_q;
    // Bits sent in this element
    logic [3:0] bit_cnt_r;

    assign ctrl_busy = ~xfer_req & ~func_done;
    assign db_access = access_p & host_a01;
    // Only loads while the link is quiet
    assign parallel_load = db_access & host_write & ~ctrl_busy;
    // Busy opens the shift path in either direction
    assign buf_shift = shift_p & ctrl_busy;

    hbdc_shift_buf u_buf (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .load_i(parallel_load),
        .load_data_i(host_data),
        .shift_i(buf_shift & (dir_in | ~bit_cnt_r[3])),
        .ser_i(ser_in & dir_in),
        .q_o(buf_q)
    );

    //------------------------------------------------------------
    // Run flip-flop
    //------------------------------------------------------------
    // Clear wins: a busy controller cannot be restarted
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            CTRL_RUN_O <= 1'b0;
        end
        else if (bus_init || ctrl_busy)
        begin
            CTRL_RUN_O <= 1'b0;
        end
        else if (db_access)
        begin
            // With done up this passes a command, else a data element
            CTRL_RUN_O <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // Outbound serial: eight bits then parity
    //------------------------------------------------------------
    // Running parity of the bits sent
    logic par_r;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            bit_cnt_r <= 4'h0;
            par_r <= hbdc_pkg::PARITY_ODD;
        end
        else if (!ctrl_busy || dir_in)
        begin
            // Idle or inbound: ready for a fresh element
            bit_cnt_r <= 4'h0;
            par_r <= hbdc_pkg::PARITY_ODD;
        end
        else if (shift_p && bit_cnt_r != hbdc_pkg::ELEM_BITS)
        begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            par_r <= par_r ^ buf_q[hbdc_pkg::BUF_W-1];
        end
    end

    // Line shows the last stage, then the parity bit
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            CTRL_SERIAL_O <= 1'b0;
        end
        else if (bit_cnt_r == hbdc_pkg::ELEM_BITS)
        begin
            CTRL_SERIAL_O <= par_r;
        end
        else
        begin
            CTRL_SERIAL_O <= buf_q[hbdc_pkg::BUF_W-1] & ~dir_in;
        end
    end

    //------------------------------------------------------------
    // Interrupt enable and rearm
    //------------------------------------------------------------
    logic irq_enable_r;
    // Set by a fresh done; spent once the vector is taken
    logic armed_r;
    hbdc_pkg::arb_e arb_r; // Arbitration state, also read by rearm

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            irq_enable_r <= 1'b0;
        end
        else if (bus_init)
        begin
            irq_enable_r <= 1'b0;
        end
        else if (access_p && !host_a01 && host_write)
        begin
            irq_enable_r <= host_data[hbdc_pkg::CSR_IEN_BIT];
        end
    end

    // Arrival beats consumption in the same cycle
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            armed_r <= 1'b0;
        end
        else if (done_rise && irq_enable_r)
        begin
            armed_r <= 1'b1;
        end
        else if (bus_init || arb_r == hbdc_pkg::ARB_MASTER && bus_ssyn)
        begin
            armed_r <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Bus arbitration
    //------------------------------------------------------------
    hbdc_pkg::arb_e arb_nxt;

    always_comb
    begin
        arb_nxt = arb_r;
        unique case (arb_r)
            hbdc_pkg::ARB_IDLE:
            begin
                // Neither acknowledge nor busy is held here
                if (func_done && irq_enable_r && armed_r)
                begin
                    arb_nxt = hbdc_pkg::ARB_REQ;
                end
            end
            hbdc_pkg::ARB_REQ:
            begin
                if (!irq_enable_r || !func_done)
                begin
                    arb_nxt = hbdc_pkg::ARB_IDLE;
                end
                else if (grant_rise)
                begin
                    arb_nxt = hbdc_pkg::ARB_SACK;
                end
            end
            hbdc_pkg::ARB_SACK:
            begin
                if (!bus_bbsy && !bus_ssyn && !grant_in)
                begin
                    arb_nxt = hbdc_pkg::ARB_MASTER;
                end
            end
            hbdc_pkg::ARB_MASTER:
            begin
                // Slave sync means the vector was taken
                if (bus_ssyn)
                begin
                    arb_nxt = hbdc_pkg::ARB_IDLE;
                end
            end
        endcase
        if (bus_init)
        begin
            arb_nxt = hbdc_pkg::ARB_IDLE;
        end
    end

    // State and registered bus outputs
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            arb_r <= hbdc_pkg::ARB_IDLE;
            BUS_BR_O <= '0;
            BUS_SACK_O <= 1'b0;
            BUS_BBSY_O <= 1'b0;
            BUS_INTR_O <= 1'b0;
        end
        else
        begin
            arb_r <= arb_nxt;
            BUS_BR_O <= '0;
            BUS_BR_O[PRIO_SEL_I] <= arb_nxt == hbdc_pkg::ARB_REQ;
            BUS_SACK_O <= arb_nxt == hbdc_pkg::ARB_SACK;
            BUS_BBSY_O <= arb_nxt == hbdc_pkg::ARB_MASTER;
            BUS_INTR_O <= arb_nxt == hbdc_pkg::ARB_MASTER;
        end
    end

    //------------------------------------------------------------
    // Host data lines: reads and vector
    //------------------------------------------------------------
    logic [hbdc_pkg::DATA_W-1:0] rd_data;
    logic [hbdc_pkg::DATA_W-1:0] rd_oe_n;

    always_comb
    begin
        rd_data = hbdc_pkg::DATA_RST;
        rd_oe_n = hbdc_pkg::OE_N_RST;
        if (arb_nxt == hbdc_pkg::ARB_MASTER)
        begin
            // Vector only while holding bus busy
            rd_data[hbdc_pkg::VEC_HI:hbdc_pkg::VEC_LO] =
                VECTOR[hbdc_pkg::VEC_HI:hbdc_pkg::VEC_LO];
            rd_oe_n = hbdc_pkg::OE_N_VEC;
        end
        else if (host_sel && !host_write && host_a01)
        begin
            rd_data[hbdc_pkg::BUF_W-1:0] = buf_q;
            rd_oe_n = hbdc_pkg::OE_N_DB;
        end
        else if (host_sel && !host_write)
        begin
            rd_data[hbdc_pkg::CSR_DONE_BIT] = func_done;
            rd_data[hbdc_pkg::CSR_IEN_BIT] = irq_enable_r;
            rd_data[hbdc_pkg::CSR_TR_BIT] = xfer_req;
            rd_data[hbdc_pkg::CSR_ERR_BIT] = ctrl_err;
            rd_oe_n = hbdc_pkg::OE_N_CSR;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            HOST_DATA_O <= hbdc_pkg::DATA_RST;
            HOST_DATA_OE_N_O <= hbdc_pkg::OE_N_RST;
        end
        else
        begin
            HOST_DATA_O <= rd_data;
            HOST_DATA_OE_N_O <= rd_oe_n;
        end
    end
endmodule : host_bus_disk_ctrl_interface

// ### tb/hbdc_link_properties.sv
// Concurrent checks on the ports of the disk link interface
`timescale 1ns/1ps
module hbdc_link_properties #(
    parameter logic [8:0] VECTOR = hbdc_pkg::VECTOR_DEF
) (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic HOST_SEL_I,
    input wire logic HOST_A01_I,
    input wire logic HOST_WRITE_I,
    input wire logic [hbdc_pkg::DATA_W-1:0] HOST_DATA_O,
    input wire logic [hbdc_pkg::DATA_W-1:0] HOST_DATA_OE_N_O,
    input wire logic BUS_INIT_I,
    input wire logic [1:0] PRIO_SEL_I,
    input wire logic [hbdc_pkg::LEVELS-1:0] BUS_BG_I,
    input wire logic BUS_BBSY_I,
    input wire logic BUS_SSYN_I,
    input wire logic [hbdc_pkg::LEVELS-1:0] BUS_BR_O,
    input wire logic BUS_SACK_O,
    input wire logic BUS_BBSY_O,
    input wire logic BUS_INTR_O,
    input wire logic CTRL_XFER_REQ_I,
    input wire logic CTRL_DONE_I,
    input wire logic CTRL_ERROR_I,
    input wire logic CTRL_RUN_O
);
    //----
    // Shared clocking and helpers
    //----
    default clocking @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!ARST_N_I);
    logic csr_rd; // Status read, not masked by a vector cycle
    assign csr_rd = HOST_SEL_I && !HOST_A01_I && !HOST_WRITE_I && !BUS_BBSY_O;

    //----
    // Run sequencing
    //----
    a_run_init_clear: assert property (BUS_INIT_I [*5] |-> !CTRL_RUN_O)
        else $error("run held through initialize");
    a_run_busy_clear: assert property ((!CTRL_XFER_REQ_I && !CTRL_DONE_I) [*5]
        |-> !CTRL_RUN_O)
        else $error("run held while busy");
    a_run_from_db: assert property ($rose(CTRL_RUN_O) |-> $past(HOST_SEL_I && HOST_A01_I))
        else $error("run set without a data buffer access");

    //----
    // Status readout
    //----
    a_csr_lines: assert property (csr_rd [*6]
        |-> HOST_DATA_OE_N_O == hbdc_pkg::OE_N_CSR)
        else $error("wrong lines enabled on status read");
    a_status_bits: assert property ((csr_rd
        && $stable({CTRL_DONE_I, CTRL_XFER_REQ_I, CTRL_ERROR_I})) [*6]
        |-> HOST_DATA_O[7] == CTRL_XFER_REQ_I && HOST_DATA_O[5] == CTRL_DONE_I
            && HOST_DATA_O[15] == CTRL_ERROR_I)
        else $error("status bits do not follow the controller");

    //----
    // Arbitration and vector
    //----
    a_req_gate: assert property (|BUS_BR_O |-> $past(!BUS_SACK_O && !BUS_BBSY_O))
        else $error("request raised while acknowledged or master");
    a_req_level: assert property (|BUS_BR_O |-> BUS_BR_O == (4'h1 << PRIO_SEL_I))
        else $error("request on the wrong level");
    a_sack_grant: assert property ($rose(BUS_SACK_O) |-> $past(|BUS_BR_O)
        && $past(BUS_BG_I[PRIO_SEL_I], 3))
        else $error("acknowledge without request and grant");
    a_take_master: assert property ($rose(BUS_BBSY_O) |-> $past(BUS_SACK_O) && !BUS_SACK_O
        && !$past(BUS_BBSY_I || BUS_SSYN_I || BUS_BG_I[PRIO_SEL_I], 3))
        else $error("mastership taken too early");
    a_master_vec: assert property (BUS_BBSY_O && $past(BUS_BBSY_O) |-> BUS_INTR_O
        && HOST_DATA_O[8:2] == VECTOR[8:2] && HOST_DATA_OE_N_O == hbdc_pkg::OE_N_VEC)
        else $error("vector or interrupt missing while master");
endmodule : hbdc_link_properties

// ### tb/hbdc_ctrl_model.sv
// Behavioural disk controller on the far side of the serial link
`timescale 1ns/1ps
module hbdc_ctrl_model (
    input wire logic run_i,
    input wire logic ser_i,
    output logic xfer_req_o,
    output logic done_o,
    output logic dir_o,
    output logic shift_o,
    output logic ser_o,
    output logic err_o
);
    localparam int HALF = 24; // Half of the 48 ns shift period
    logic cmd_r = 1'b0; // Last run came while done was true
    initial
    begin
        {err_o, xfer_req_o, done_o} = 3'h1;
        dir_o = 1'b0;
        shift_o = 1'b0; // Shift clock stands still outside frames
        ser_o = 1'b1;
    end
    // Run while done carries a command, otherwise a data element
    always @(posedge run_i)
        cmd_r = done_o;
    // Status lines: error, transfer request, done
    task state(input logic [2:0] v);
        {err_o, xfer_req_o, done_o} = v;
    endtask : state
    // Controller to interface: shift a byte in, then flag it ready
    task send(input logic [7:0] b);
        int i;
        #1;
        dir_o = 1'b1;
        xfer_req_o = 1'b0;
        for (i = 7; i >= 0; i--)
        begin
            ser_o = b[i];
            #(HALF);
            shift_o = 1'b1;
            #(HALF);
            shift_o = 1'b0;
        end
        ser_o = ~b[0]; // Released line shows the inverse, not a stale bit
        #(HALF);
        xfer_req_o = 1'b1;
    endtask : send
    // Interface to controller: clock out eight bits and parity
    task recv(output logic [8:0] e);
        int i;
        #1;
        dir_o = 1'b0;
        {xfer_req_o, done_o} = 2'h0;
        for (i = 0; i < 9; i++)
        begin
            #(HALF);
            e = {e[7:0], ser_i};
            shift_o = 1'b1;
            #(HALF);
            shift_o = 1'b0;
        end
        #(HALF);
        xfer_req_o = 1'b1;
    endtask : recv
endmodule : hbdc_ctrl_model

// ### tb/tb_host_bus_disk_ctrl_interface.sv
// Self-checking bench for the host-bus disk controller interface
`timescale 1ns/1ps
module tb_host_bus_disk_ctrl_interface;
    //----
    // Signals
    //----
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sel = 1'b0;
    logic a01 = 1'b0;
    logic wr = 1'b0;
    logic [7:0] din = 8'h00;
    logic init = 1'b0;
    logic [1:0] prio = hbdc_pkg::PRIO_DEF; // Plug is static
    logic [3:0] bg = 4'h0;
    logic bbsy_in = 1'b0;
    logic ssyn = 1'b0;
    logic [15:0] dout, oe_n;
    logic [3:0] br;
    logic sack, bbsy, intr, run, ser_out, ini;
    logic xreq, done, dir, shift, ser_in, err;
    int error_cnt = 0;
    int checked = 0;
    int i;
    logic [15:0] seed = 16'h01C4;
    logic [15:0] q, qoe;
    logic [8:0] e;
    logic [7:0] b;

    always #2 clk = ~clk;

    host_bus_disk_ctrl_interface uut (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .HOST_SEL_I(sel),
        .HOST_A01_I(a01), .HOST_WRITE_I(wr), .HOST_DATA_I(din), .HOST_DATA_O(dout),
        .HOST_DATA_OE_N_O(oe_n), .BUS_INIT_I(init), .PRIO_SEL_I(prio), .BUS_BG_I(bg),
        .BUS_BBSY_I(bbsy_in), .BUS_SSYN_I(ssyn), .BUS_BR_O(br), .BUS_SACK_O(sack),
        .BUS_BBSY_O(bbsy), .BUS_INTR_O(intr), .CTRL_XFER_REQ_I(xreq), .CTRL_DONE_I(done),
        .CTRL_TO_HOST_DIR_I(dir), .CTRL_SHIFT_I(shift), .CTRL_SERIAL_I(ser_in),
        .CTRL_ERROR_I(err), .CTRL_RUN_O(run), .CTRL_SERIAL_O(ser_out), .CTRL_INIT_O(ini));
    hbdc_ctrl_model ctl (.run_i(run), .ser_i(ser_out), .xfer_req_o(xreq), .done_o(done),
        .dir_o(dir), .shift_o(shift), .ser_o(ser_in), .err_o(err));

    //----
    // Helpers
    //----
    // Next random byte from the shift register
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : rnd
    // Serial element: data then odd parity
    function automatic logic [8:0] elem(input logic [7:0] d);
        return {d, ~^d};
    endfunction : elem
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task end_sim;
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    function logic pick(input int w);
        case (w)
            1: return |br;
            2: return sack;
            default: return bbsy;
        endcase
    endfunction : pick
    // Bounded wait on a bus handshake output
    task wait_on(input int w, input logic v);
        int n;
        for (n = 0; n < 200 && pick(w) !== v; n++)
            @(negedge clk);
        if (n == 200)
        begin
            error_cnt++;
            $display("mismatch wait %0d expected %b seen timeout", w, v);
            end_sim();
        end
    endtask : wait_on
    // One register access; select held until the answer has settled
    task host(input logic a, input logic w, input logic [7:0] d);
        {sel, a01, wr, din} = {1'b1, a, w, d};
        repeat (6) @(negedge clk);
        q = dout;
        qoe = oe_n;
        sel = 1'b0;
        repeat (3) @(negedge clk);
    endtask : host

    //----
    // Main sequence
    //----
    initial
    begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        check("oe_rst", oe_n, hbdc_pkg::OE_N_RST);
        $display("test reset done");
        // Every combination of done, request and error
        for (i = 0; i < 8; i++)
        begin
            ctl.state(i[2:0]);
            host(1'b0, 1'b0, 8'h00);
            check("csr", q & 16'h80A0, {i[2], 7'h0, i[1], 1'b0, i[0], 5'h0});
            check("csr_oe", qoe, hbdc_pkg::OE_N_CSR);
        end
        $display("test status done");
        // Host to controller: one command, then data with a full byte last
        for (i = 0; i < 4; i++)
        begin
            ctl.state({1'b0, i != 0, i == 0});
            b = rnd();
            if (i == 3)
                b = 8'hFF;
            host(1'b1, 1'b1, b);
            check("run_set", run, 1);
            check("cmd", ctl.cmd_r, i == 0);
            ctl.recv(e);
            check("elem", e, elem(b));
            check("run_clr", run, 0);
        end
        $display("test outbound done");
        // Controller to host: bytes shifted in, zero first
        for (i = 0; i < 4; i++)
        begin
            b = rnd();
            if (i == 0)
                b = 8'h00;
            ctl.send(b);
            @(negedge clk);
            host(1'b1, 1'b0, 8'h00);
            check("db", q[7:0], b);
            check("db_oe", qoe, hbdc_pkg::OE_N_DB);
            check("run_next", run, 1);
        end
        $display("test inbound done");
        // Initialize drops a pending run
        host(1'b1, 1'b1, 8'h5A);
        init = 1'b1;
        repeat (6) @(negedge clk);
        check("run_init", run, 0);
        check("init_out", ini, 1);
        init = 1'b0;
        $display("test init done");
        // Interrupt: enable, request, grant, mastership, vector, release
        ctl.state(3'h2);
        host(1'b0, 1'b1, 8'h40);
        host(1'b0, 1'b0, 8'h00);
        check("ien", q[6], 1);
        ctl.state(3'h3);
        wait_on(1, 1'b1);
        check("br", br, 4'h1 << prio);
        bg = br;
        bbsy_in = 1'b1;
        wait_on(2, 1'b1);
        bg = 4'h0;
        repeat (10) @(negedge clk);
        check("br_off", br, 0);
        check("bbsy_wait", bbsy, 0);
        bbsy_in = 1'b0;
        wait_on(3, 1'b1);
        repeat (2) @(negedge clk);
        check("sack_clr", sack, 0);
        check("intr", intr, 1);
        check("vec", dout[8:2], hbdc_pkg::VECTOR_DEF[8:2]);
        check("vec_oe", oe_n, hbdc_pkg::OE_N_VEC);
        ssyn = 1'b1;
        wait_on(3, 1'b0);
        ssyn = 1'b0;
        repeat (20) @(negedge clk);
        check("no_rearm", br, 0);
        ctl.state(3'h2);
        repeat (4) @(negedge clk);
        ctl.state(3'h3);
        wait_on(1, 1'b1);
        $display("test interrupt done");
        end_sim();
    end
endmodule : tb_host_bus_disk_ctrl_interface

bind host_bus_disk_ctrl_interface hbdc_link_properties #(.VECTOR(VECTOR)) u_chk (
    .CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .HOST_SEL_I(HOST_SEL_I),
    .HOST_A01_I(HOST_A01_I), .HOST_WRITE_I(HOST_WRITE_I), .HOST_DATA_O(HOST_DATA_O),
    .HOST_DATA_OE_N_O(HOST_DATA_OE_N_O), .BUS_INIT_I(BUS_INIT_I), .PRIO_SEL_I(PRIO_SEL_I),
    .BUS_BG_I(BUS_BG_I), .BUS_BBSY_I(BUS_BBSY_I), .BUS_SSYN_I(BUS_SSYN_I),
    .BUS_BR_O(BUS_BR_O), .BUS_SACK_O(BUS_SACK_O), .BUS_BBSY_O(BUS_BBSY_O),
    .BUS_INTR_O(BUS_INTR_O), .CTRL_XFER_REQ_I(CTRL_XFER_REQ_I), .CTRL_DONE_I(CTRL_DONE_I),
    .CTRL_ERROR_I(CTRL_ERROR_I), .CTRL_RUN_O(CTRL_RUN_O));
